// [hw/posfb_consts.vh]
// Constants for the position feedback output block
// Summary of operation
// - Serial port only transmits; it has no receive path.
// - Message is header (only when enabled) then payload, CRC appended only when enabled.
// - Multi-byte values go most significant byte first.
// - Controller drives the shift clock; device makes no clock of its own.
// - Data output updates on each rising edge of the incoming clock, plain binary.
// - Each transfer carries one 32-bit data word.
// - A 16-bit selector picks which internal variable goes out serially.
// - Serial position is signed 32-bit: actuator position minus home offset.
// - A/B outputs active only while simulation enable is 1; default off.
// - Writing 1 to simulation reset clears the accumulator; 0 leaves it.
// - Index type 0 keeps default index, 1 gives a 50/50 index marker.
// - Generator update rate is set in MHz multiples, default 20.
// - Generator counter wraps at a configurable modulus, default 536870912.
// - Output resolution default 8192 ppr; drive resolution default 65536 counts.
// - Delta of positions is scaled by 3.2768; integer part goes to generator.
// - Generator accepts a 16-bit delta at each update with no steps pending and makes A/B signals.
`ifndef POSFB_CONSTS_VH
`define POSFB_CONSTS_VH
`define CLK_MHZ          8'd25
`define SEL_POSITION     16'hFA4E
`define SEL_WIDTH        16
`define WORD_BITS        6'd32
`define HEADER_BITS      6'd8
`define HEADER_VALUE     8'hA5
`define CRC_POLY         8'h07
`define CRC_INIT         8'h00
`define GAP_NS           20000
`define GAP_CYCLES       ((`GAP_NS * 25 + 999) / 1000)
`define RATE_DEFAULT     8'h14
`define MOD_DEFAULT      32'h20000000
`define PPR_DEFAULT      32'h00002000
`define RESOL_DEFAULT    32'h00010000
`define MULT_DEFAULT     32'h0000D1B7
`define MULT_FRAC_BITS   14
`define PRESCALE_MAX     8'hFF
`endif

// [hw/posfb_out.v]
// Serial feedback transmitter and simulated quadrature encoder generator
`timescale 1ns/1ps
`default_nettype none
`include "posfb_consts.vh"
module posfb_out (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RST_N,
    // Serial link from the controller
    input  wire        SER_CLK,
    output reg         SER_DATA,
    // Serial configuration
    input  wire [15:0] VAR_SELECT,
    input  wire        CRC_ENABLE,
    input  wire        HEADER_ENABLE,
    // Internal variables
    input  wire [31:0] ACTUATOR_POS,
    input  wire [31:0] HOME_OFFSET,
    input  wire [31:0] AUX_VAR,
    // Simulation configuration
    input  wire        SIM_ENABLE,
    input  wire        SIM_RESET,
    input  wire        INDEX_TYPE,
    input  wire [7:0]  UPDATE_RATE,
    input  wire [31:0] COUNTER_MOD,
    input  wire [31:0] DELTA_MULT,
    input  wire        INDEX_IN,
    // Simulated encoder outputs
    output reg         ENC_A,
    output reg         ENC_B,
    output reg         ENC_INDEX,
    output wire [31:0] SIM_COUNT
);
    //--------------------------------------------------------------
    // Link clock synchroniser
    //--------------------------------------------------------------
    // The controller's clock is unrelated to the core clock, so it is
    // only read after two flip-flops; a third copy finds the rising edge.
    // An edge is therefore seen about three core cycles after the pin moves.
    reg        sclk_s1_ff;
    reg        sclk_s2_ff;
    reg        sclk_d_ff;
    wire       sclk_rise = sclk_s2_ff & ~sclk_d_ff;

    // Two stages before use; third stage finds edges
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_s1_ff <= 1'b1;
            sclk_s2_ff <= 1'b1;
            sclk_d_ff  <= 1'b1;
        end else begin
            sclk_s1_ff <= SER_CLK;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_d_ff  <= sclk_s2_ff;
        end
    end

    //--------------------------------------------------------------
    // Variable selection
    //--------------------------------------------------------------
    // The word is formed continuously; the transmitter freezes it at the
    // first clock edge of a frame, so a later move cannot tear the word
    wire [31:0] serial_feedback_position = ACTUATOR_POS - HOME_OFFSET;
    wire [31:0] sel_word = (VAR_SELECT == `SEL_POSITION) ?
                           serial_feedback_position : AUX_VAR;

    //--------------------------------------------------------------
    // Serial transmitter (transmit only, clocked by the controller)
    //--------------------------------------------------------------
    // no receive path; bit rate follows the controller's clock only
    // Extra clocks after the last bit read back as 1; a frame ends only after the
    // clock rests for the gap time; the next rise then starts a new frame
    reg [47:0] shift_ff;
    reg [6:0]  left_ff;
    reg        busy_ff;
    reg [9:0]  gap_ff;
    reg [7:0]  crc_ff;
    reg        crc_en_ff;
    reg [7:0]  nxt_crc;
    integer    k;

    // Header pattern and the layout of the frame chosen at its first edge
    wire [7:0]  header_word = `HEADER_VALUE;
    reg         nxt_first;
    reg  [47:0] nxt_shift;
    reg  [6:0]  nxt_left;
    wire        gap_done = (gap_ff == `GAP_CYCLES);

    // First bit out, bits still to come, and the rest of the frame;
    // the checksum byte is dropped into the zero tail while shifting
    always @* begin
        nxt_first = sel_word[31];
        nxt_shift = {sel_word[30:0], 17'h00000};
        nxt_left  = 7'd31;
        case ({HEADER_ENABLE, CRC_ENABLE})
            2'b00: begin
                nxt_first = sel_word[31];
                nxt_shift = {sel_word[30:0], 17'h00000};
                nxt_left  = 7'd31;
            end
            2'b01: begin
                nxt_first = sel_word[31];
                nxt_shift = {sel_word[30:0], 17'h00000};
                nxt_left  = 7'd39;
            end
            2'b10: begin
                nxt_first = header_word[7];
                nxt_shift = {header_word[6:0], sel_word, 9'h000};
                nxt_left  = 7'd39;
            end
            2'b11: begin
                nxt_first = header_word[7];
                nxt_shift = {header_word[6:0], sel_word, 9'h000};
                nxt_left  = 7'd47;
            end
            default: begin
                nxt_first = sel_word[31];
                nxt_shift = {sel_word[30:0], 17'h00000};
                nxt_left  = 7'd31;
            end
        endcase
    end

    // CRC-8 over the 32-bit payload only, taken once at capture
    always @* begin
        nxt_crc = `CRC_INIT;
        for (k = 31; k >= 0; k = k - 1) begin
            nxt_crc = {nxt_crc[6:0], 1'b0} ^
                      ((nxt_crc[7] ^ sel_word[k]) ? `CRC_POLY : 8'h00);
        end
    end

    // Gap timeout ends a frame when the clock stops
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_ff  <= 48'h000000000000;
            left_ff   <= 7'h00;
            busy_ff   <= 1'b0;
            gap_ff    <= 10'h000;
            crc_ff    <= 8'h00;
            crc_en_ff <= 1'b0;
            SER_DATA  <= 1'b1;
        end else if (sclk_rise) begin
            gap_ff <= 10'h000;
            if (!busy_ff) begin
                // word captured at the first edge and held
                busy_ff   <= 1'b1;
                crc_en_ff <= CRC_ENABLE;
                crc_ff    <= nxt_crc;
                SER_DATA  <= nxt_first;
                shift_ff  <= nxt_shift;
                left_ff   <= nxt_left;
            end else if (left_ff != 7'h00) begin
                SER_DATA <= shift_ff[47];
                shift_ff <= {shift_ff[46:0], 1'b0};
                left_ff  <= left_ff - 7'd1;
                if (crc_en_ff && left_ff == 7'd9)
                    shift_ff[47:40] <= crc_ff;
            end else begin
                SER_DATA <= 1'b1;
            end
        end else if (busy_ff) begin
            if (gap_done) begin
                busy_ff  <= 1'b0;
                SER_DATA <= 1'b1;
            end else begin
                gap_ff <= gap_ff + 10'h001;
            end
        end
    end

    //--------------------------------------------------------------
    // Update tick: UPDATE_RATE in MHz relative to the core clock
    //--------------------------------------------------------------
    // rate accumulator produces UPDATE_RATE/CLK_MHZ ticks (capped at 1)
    // Rates at or above the core clock give a tick on every cycle
    reg [8:0]  rate_acc_ff;
    wire [8:0] rate_sum = rate_acc_ff + {1'b0, UPDATE_RATE};
    wire       tick = (rate_sum >= {1'b0, `CLK_MHZ});

    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N)
            rate_acc_ff <= 9'h000;
        else if (tick)
            rate_acc_ff <= (rate_sum - {1'b0, `CLK_MHZ}) % {1'b0, `CLK_MHZ};
        else
            rate_acc_ff <= rate_sum;
    end

    //--------------------------------------------------------------
    // Delta scaling with fractional carry
    //--------------------------------------------------------------
    // DELTA_MULT is unsigned with 14 fraction bits; bit 31 is ignored so
    // the product stays signed. No update is taken while steps are still
    // pending, so a fast move spreads over later updates and is not lost.
    reg  [31:0] prev_pos_ff;
    reg  [13:0] frac_ff;
    wire [31:0] delta_pos = ACTUATOR_POS - prev_pos_ff;
    wire [63:0] scaled = $signed(delta_pos) * $signed({1'b0, DELTA_MULT[30:0]})
                       + $signed({50'h0, frac_ff});
    wire [15:0] int_delta = scaled[29:14];
    reg  [15:0] pend_ff;
    reg         pend_dir_ff;
    reg  [31:0] count_ff;
    reg  [1:0]  phase_ff;

    // Direction and size of the integer step; a negative delta counts down
    wire        step_dir = int_delta[15];
    wire [15:0] step_mag = step_dir ? (16'h0000 - int_delta) : int_delta;

    // Neighbours of the count, wrapped at the modulus
    wire [31:0] mod_top  = COUNTER_MOD - 32'h00000001;
    wire [31:0] count_up = (count_ff >= mod_top) ? 32'h00000000 : count_ff + 32'h00000001;
    wire [31:0] count_dn = (count_ff == 32'h00000000) ? mod_top : count_ff - 32'h00000001;

    // Previous position, remainder and pending edges
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_pos_ff <= 32'h00000000;
            frac_ff     <= 14'h0000;
            pend_ff     <= 16'h0000;
            pend_dir_ff <= 1'b0;
            count_ff    <= 32'h00000000;
            phase_ff    <= 2'h0;
        end else if (SIM_RESET) begin
            prev_pos_ff <= ACTUATOR_POS;
            frac_ff     <= 14'h0000;
            pend_ff     <= 16'h0000;
            count_ff    <= 32'h00000000;
        end else begin
            if (tick && pend_ff == 16'h0000) begin
                prev_pos_ff <= ACTUATOR_POS;
                frac_ff     <= scaled[13:0];
                pend_dir_ff <= step_dir;
                pend_ff     <= step_mag;
            end else if (pend_ff != 16'h0000) begin
                pend_ff <= pend_ff - 16'h0001;
                if (pend_dir_ff) begin
                    phase_ff <= phase_ff - 2'h1;
                    count_ff <= count_dn;
                end else begin
                    phase_ff <= phase_ff + 2'h1;
                    count_ff <= count_up;
                end
            end
        end
    end

    assign SIM_COUNT = count_ff;

    //--------------------------------------------------------------
    // Quadrature and index outputs
    //--------------------------------------------------------------
    // Steps keep running while disabled, so the count stays true and
    // only the pins are gated; enabling never replays missed steps
    reg         nxt_enc_a;
    reg         nxt_enc_b;
    wire [31:0] ppr_half = `PPR_DEFAULT >> 1;
    wire        idx_half = ({19'h00000, count_ff[12:0]} < ppr_half);

    // Gray phase: 00,10,11,01 so B lags A when counting up
    always @* begin
        nxt_enc_a = 1'b0;
        nxt_enc_b = 1'b0;
        case (phase_ff)
            2'h0: begin
                nxt_enc_a = 1'b0;
                nxt_enc_b = 1'b0;
            end
            2'h1: begin
                nxt_enc_a = 1'b1;
                nxt_enc_b = 1'b0;
            end
            2'h2: begin
                nxt_enc_a = 1'b1;
                nxt_enc_b = 1'b1;
            end
            2'h3: begin
                nxt_enc_a = 1'b0;
                nxt_enc_b = 1'b1;
            end
            default: begin
                nxt_enc_a = 1'b0;
                nxt_enc_b = 1'b0;
            end
        endcase
    end

    // Registered pins; the marker sits high for the first half revolution
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ENC_A     <= 1'b0;
            ENC_B     <= 1'b0;
            ENC_INDEX <= 1'b0;
        end else begin
            ENC_A <= SIM_ENABLE & nxt_enc_a;
            ENC_B <= SIM_ENABLE & nxt_enc_b;
            if (INDEX_TYPE)
                ENC_INDEX <= SIM_ENABLE & idx_half;
            else
                ENC_INDEX <= INDEX_IN;
        end
    end
endmodule // posfb_out
`default_nettype wire

// [test/posfb_out_asserts.sv]
// Checker for the serial feedback port and the simulated encoder outputs
`timescale 1ns/1ps
`default_nettype none
module posfb_chk (
    // Clock, reset and link
    input wire logic        CORE_CLK, RST_N, SER_CLK, SER_DATA,
    // Simulation controls and outputs
    input wire logic        SIM_ENABLE, SIM_RESET, INDEX_TYPE, INDEX_IN, ENC_A, ENC_B, ENC_INDEX,
    input wire logic [31:0] COUNTER_MOD, SIM_COUNT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Core cycles since the link clock was last seen high, saturating
    logic [9:0] idle_ff;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) idle_ff <= 10'h000;
        else idle_ff <= SER_CLK ? 10'h000 : idle_ff + {9'h000, idle_ff != 10'h3FF};
    end
    property p_fall_on_edge; $fell(SER_DATA) |-> $past(SER_CLK, 3) || $past(SER_CLK, 4) || $past(SER_CLK, 5); endproperty
    a_fall_on_edge: assert property (p_fall_on_edge) else $error("data fell with no clock rise");
    property p_idle_high; idle_ff >= 10'd520 |-> SER_DATA; endproperty
    a_idle_high: assert property (p_idle_high) else $error("data not high at idle");
    property p_sim_off; !SIM_ENABLE && !$past(SIM_ENABLE) && !$past(SIM_ENABLE, 2) |-> !ENC_A && !ENC_B; endproperty
    a_sim_off: assert property (p_sim_off) else $error("A/B active while disabled");
    property p_quarter; SIM_ENABLE && $past(SIM_ENABLE) && !SIM_RESET |-> !($changed(ENC_A) && $changed(ENC_B)); endproperty
    a_quarter: assert property (p_quarter) else $error("A and B moved together");
    property p_clear; $past(SIM_RESET) && $past(SIM_RESET, 2) |-> SIM_COUNT == 32'h00000000; endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");
    property p_below_mod; COUNTER_MOD != 32'h00000000 |-> SIM_COUNT < COUNTER_MOD; endproperty
    a_below_mod: assert property (p_below_mod) else $error("count beyond modulus");
    property p_index_pass; !INDEX_TYPE && !$past(INDEX_TYPE) |-> ENC_INDEX == $past(INDEX_IN); endproperty
    a_index_pass: assert property (p_index_pass) else $error("native index not passed");
    property p_index_gate; INDEX_TYPE && $past(INDEX_TYPE) && !SIM_ENABLE && !$past(SIM_ENABLE) |-> !ENC_INDEX; endproperty
    a_index_gate: assert property (p_index_gate) else $error("marker active while disabled");
    c_data: cover property ($fell(SER_DATA));
    c_enc_b: cover property ($rose(ENC_B));
    c_count: cover property (SIM_COUNT != 32'h00000000);
endmodule // posfb_chk
bind posfb_out posfb_chk chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SER_CLK(SER_CLK),
    .SER_DATA(SER_DATA), .SIM_ENABLE(SIM_ENABLE), .SIM_RESET(SIM_RESET), .INDEX_TYPE(INDEX_TYPE),
    .INDEX_IN(INDEX_IN), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_INDEX(ENC_INDEX),
    .COUNTER_MOD(COUNTER_MOD), .SIM_COUNT(SIM_COUNT));
`default_nettype wire

// [test/ssi_ctrl_model.sv]
// Controller model that clocks serial words out of the feedback port
`timescale 1ns/1ps
`default_nettype none
module ssi_ctrl_model (
    // Link
    output var logic SER_CLK,
    input  wire logic SER_DATA
);
    initial SER_CLK = 1'b0;
    // Clock in n bits, sampling late in each period; the clock rests low between frames
    task automatic read_bits(input int n, output logic [47:0] word);
        word = 48'h0;
        #5; // Keep link edges clear of the core clock edges
        repeat (n) begin
            SER_CLK = 1'b1;
            #160 SER_CLK = 1'b0;
            #150 word = {word[46:0], SER_DATA};
            #10;
        end
        #21000;
    endtask
endmodule // ssi_ctrl_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the position feedback output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        CORE_CLK = 1'b0, RST_N = 1'b0, CRC_ENABLE = 1'b0, HEADER_ENABLE = 1'b0;
    logic        SIM_ENABLE = 1'b0, SIM_RESET = 1'b0, INDEX_TYPE = 1'b0, INDEX_IN = 1'b0;
    logic [15:0] VAR_SELECT = 16'hFA4E;
    logic [7:0]  UPDATE_RATE = 8'h14;
    logic [31:0] ACTUATOR_POS = 32'h0, HOME_OFFSET = 32'h100, AUX_VAR = 32'hC3A50F96;
    logic [31:0] COUNTER_MOD = 32'h20000000, DELTA_MULT = 32'h4000;
    logic [47:0] word;
    wire logic   SER_CLK, SER_DATA, ENC_A, ENC_B, ENC_INDEX;
    wire logic [31:0] SIM_COUNT;
    int          bad_count = 0, check_count = 0;
    always #20 CORE_CLK = ~CORE_CLK;
    posfb_out dut_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SER_CLK(SER_CLK), .SER_DATA(SER_DATA),
        .VAR_SELECT(VAR_SELECT), .CRC_ENABLE(CRC_ENABLE), .HEADER_ENABLE(HEADER_ENABLE),
        .ACTUATOR_POS(ACTUATOR_POS), .HOME_OFFSET(HOME_OFFSET), .AUX_VAR(AUX_VAR),
        .SIM_ENABLE(SIM_ENABLE), .SIM_RESET(SIM_RESET), .INDEX_TYPE(INDEX_TYPE),
        .UPDATE_RATE(UPDATE_RATE), .COUNTER_MOD(COUNTER_MOD), .DELTA_MULT(DELTA_MULT),
        .INDEX_IN(INDEX_IN), .ENC_A(ENC_A), .ENC_B(ENC_B), .ENC_INDEX(ENC_INDEX),
        .SIM_COUNT(SIM_COUNT));
    ssi_ctrl_model ctrl_u (.SER_CLK(SER_CLK), .SER_DATA(SER_DATA));
    // Compare and count
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // CRC-8, polynomial 07, zero start, payload MSB first
    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // Move the position, let the generator settle, compare the count
    task automatic move(input logic [31:0] mult, input logic [31:0] delta, input logic [31:0] exp);
        @(posedge CORE_CLK);
        DELTA_MULT <= mult;
        ACTUATOR_POS <= ACTUATOR_POS + delta;
        repeat (100) @(posedge CORE_CLK);
        check("sim count", {16'h0, exp}, {16'h0, SIM_COUNT});
    endtask
    // Cut a hang short
    initial begin
        #3000000 bad_count++;
        give_verdict;
    end
    initial begin
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        ACTUATOR_POS <= 32'h80000005;
        // Position word, changed mid-frame; one extra clock must give a one
        fork
            ctrl_u.read_bits(33, word);
            begin repeat (50) @(posedge CORE_CLK); ACTUATOR_POS <= 32'h0; end
        join
        check("position word", {15'h0, 32'h7FFFFF05, 1'b1}, word);
        // Header, other variable and checksum
        VAR_SELECT <= 16'h0001;
        HEADER_ENABLE <= 1'b1;
        CRC_ENABLE <= 1'b1;
        ctrl_u.read_bits(48, word);
        check("framed word", {8'hA5, 32'hC3A50F96, crc8(32'hC3A50F96)}, word);
        // Quadrature: unit gain, half gain with carried fraction, reverse
        SIM_ENABLE <= 1'b1;
        SIM_RESET <= 1'b1;
        @(posedge CORE_CLK) SIM_RESET <= 1'b0;
        move(32'h4000, 32'd10, 32'd10);
        move(32'h2000, 32'd3, 32'd11);
        move(32'h2000, 32'd3, 32'd13);
        move(32'h2000, 32'd3, 32'd14);
        move(32'h4000, 32'hFFFFFFF6, 32'd4);
        // Disabled outputs, 50/50 marker held off, then clear
        SIM_ENABLE <= 1'b0;
        INDEX_TYPE <= 1'b1;
        move(32'h4000, 32'd5, 32'd9);
        check("quadrature off", 48'h0, {46'h0, ENC_A, ENC_B});
        check("marker off", 48'h0, {47'h0, ENC_INDEX});
        SIM_ENABLE <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        check("marker", 48'h1, {47'h0, ENC_INDEX});
        SIM_RESET <= 1'b1;
        move(32'h4000, 32'd0, 32'd0);
        // Native index passes through
        INDEX_TYPE <= 1'b0;
        INDEX_IN <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        check("index", 48'h1, {47'h0, ENC_INDEX});
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
